// ---- inc/ahp_pkg.sv ----
/*
 * shared constants for the parallel drive port: task-file addresses,
 * jumper codes, master/slave handshake timing, feature codes.
 * assumes both ends run on one 200 MHz clock with all pins synchronous.
 */
package ahp_pkg;
    // ------------------------------------------------------------------
    // bus widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 3;
    localparam int NUM_REGS = 8;

    // ------------------------------------------------------------------
    // task-file addresses (select 0 side)
    // ------------------------------------------------------------------
    localparam logic [2:0] TF_DATA     = 3'h0;
    localparam logic [2:0] TF_ERROR    = 3'h1;
    localparam logic [2:0] TF_COUNT    = 3'h2;
    localparam logic [2:0] TF_LBA0     = 3'h3;
    localparam logic [2:0] TF_LBA1     = 3'h4;
    localparam logic [2:0] TF_LBA2     = 3'h5;
    localparam logic [2:0] TF_DEVHEAD  = 3'h6;
    localparam logic [2:0] TF_CMDSTAT  = 3'h7;
    // control block (select 1 side)
    localparam logic [2:0] CB_ALTSTAT  = 3'h6;

    // ------------------------------------------------------------------
    // commands and feature codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_SET_FEAT  = 8'hEF;
    localparam logic [7:0] FEAT_8BIT_ON  = 8'h01;
    localparam logic [7:0] FEAT_8BIT_OFF = 8'h81;

    // status and device control bits
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DRQ = 3;
    localparam int DC_NIEN = 1;
    localparam int DC_SRST = 2;
    localparam int DH_DEV = 4;

    // ------------------------------------------------------------------
    // jumpers: bit0=A .. bit3=D; code for B linked to D
    // ------------------------------------------------------------------
    localparam logic [3:0] JMP_NONE = 4'h0;
    localparam logic [3:0] JMP_B_D  = 4'hA;

    // ------------------------------------------------------------------
    // handshake timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int PRESENT_US = 1;
    localparam int PRESENT_CYC = PRESENT_US * CLK_MHZ;
    localparam int CNT_W = 12;
endpackage

// ---- inc/ahp_if.sv ----
/*
 * pins of the parallel drive port between host and drive.
 * assumes the bench resolves the two-way lines from the enables.
 */
`timescale 1ns/1ps
interface ahp_if;
    logic        rst_n;
    logic        cs0_n;
    logic        cs1_n;
    logic [2:0]  addr;
    logic        rd_n;
    logic        wr_n;
    logic [15:0] dh;
    logic        dh_oe;
    logic [15:0] dd;
    logic        dd_oe;
    logic [15:0] data;
    logic        intrq;
    logic        cblsel_n;
    logic        dmareq;
    logic        dmaack_n;
    logic        wide_n;
    logic        iordy;
    logic        active_in;
    logic        active_out;
    logic        active_oe;
    logic        diag_in;
    logic        diag_out;
    logic        diag_oe;

    modport host (
        output rst_n, cs0_n, cs1_n, addr, rd_n, wr_n, dh, dh_oe, dmaack_n,
        input  data, intrq, dmareq, wide_n, iordy
    );
    modport drive (
        input  rst_n, cs0_n, cs1_n, addr, rd_n, wr_n, data, cblsel_n,
        input  dmaack_n, active_in, diag_in,
        output dd, dd_oe, intrq, dmareq, wide_n, iordy,
        output active_out, active_oe, diag_out, diag_oe
    );
endinterface

// ---- logic/ahp_drive.sv ----
/*
 * drive end: task file, pio data path through a two-entry buffer,
 * interrupt, role selection and master/slave handshake lines.
 * assumes host strobes are synchronous to core_clk_i and
 * held for at least two cycles.
 */
`timescale 1ns/1ps
// Summary of operation
// - task-file access is one byte, low lines
// - data register moves 16-bit words
// - writes taken on rising write strobe
// - drive bus only during read strobe
// - interrupt request output is active high
// - three address lines pick eight registers
// - select0 task file, select1 control block
// - cable select grounded master, open slave
// - no jumpers means master always
// - jumper b to d uses cable select
// - low reset pin resets the drive
// - active/present line driven and sensed
// - diagnostic line driven and sensed
// - ready never pulled, no wait states
// - data register 16-bit until 8-bit feature
module ahp_drive #(
    parameter int DEPTH = 2
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    ahp_if.drive             bus,
    input  wire logic [3:0]  jumper_i,
    output logic             is_master_o,
    output logic             slave_seen_o,
    output logic             diag_seen_o,
    output logic [7:0]       cmd_o,
    output logic             cmd_vld_o,
    output logic [15:0]      wdat_o,
    output logic             wdat_vld_o,
    input  wire logic        wdat_rdy_i,
    input  wire logic [15:0] rdat_i,
    input  wire logic        rdat_vld_i,
    output logic             rdat_rdy_o,
    input  wire logic        irq_set_i,
    input  wire logic        drq_i
);
    // ------------------------------------------------------------------
    // reset and strobe edges
    // ------------------------------------------------------------------
    logic rst_n;
    assign rst_n = rst_n_i & bus.rst_n;
    logic wr_q, wr_d, rd_q, rd_d;
    logic wr_rise, rd_fall, sel0, sel1;
    assign sel0 = ~bus.cs0_n & bus.cs1_n;
    assign sel1 = bus.cs0_n & ~bus.cs1_n;
    assign wr_d = bus.wr_n;
    assign rd_d = bus.rd_n;
    assign wr_rise = bus.wr_n & ~wr_q;
    assign rd_fall = ~bus.rd_n & rd_q;

    // ------------------------------------------------------------------
    // task file state
    // ------------------------------------------------------------------
    logic [7:0] regs_q [ahp_pkg::NUM_REGS];
    logic [7:0] regs_d [ahp_pkg::NUM_REGS];
    logic [7:0] devctl_q, devctl_d;
    logic       byte_mode_q, byte_mode_d;
    logic       irq_q, irq_d;
    logic [7:0] cmd_q, cmd_d;
    logic       cmd_vld_q, cmd_vld_d;
    logic [7:0] lo_q, lo_d;
    logic       half_q, half_d;

    // ------------------------------------------------------------------
    // write buffer (host to back end)
    // ------------------------------------------------------------------
    logic [15:0] wb_q [DEPTH];
    logic [15:0] wb_d [DEPTH];
    logic [1:0]  wcnt_q, wcnt_d;
    logic        wpush, wfull;
    logic [15:0] wword;
    assign wfull = (wcnt_q == 2'(DEPTH));

    // ------------------------------------------------------------------
    // read buffer (back end to host)
    // ------------------------------------------------------------------
    logic [15:0] rb_q [DEPTH];
    logic [15:0] rb_d [DEPTH];
    logic [1:0]  rcnt_q, rcnt_d;
    logic        rpop;
    assign rdat_rdy_o = (rcnt_q != 2'(DEPTH));

    logic [15:0] dd_q, dd_d;
    logic [7:0]  status;
    logic [2:0]  a;
    assign a = bus.addr;
    assign status = {1'b0, 1'b1, 2'b00, drq_i | (rcnt_q != 2'h0), 3'b000};

    always_comb begin
        for (int i = 0; i < ahp_pkg::NUM_REGS; i++) begin
            regs_d[i] = regs_q[i];
        end
        devctl_d = devctl_q;
        byte_mode_d = byte_mode_q;
        irq_d = irq_q;
        cmd_d = cmd_q;
        cmd_vld_d = 1'b0;
        lo_d = lo_q;
        half_d = half_q;
        wpush = 1'b0;
        wword = 16'h0000;
        rpop = 1'b0;
        dd_d = dd_q;
        if (wr_rise && sel0) begin
            if (a == ahp_pkg::TF_DATA) begin
                if (byte_mode_q) begin
                    half_d = ~half_q;
                    lo_d = bus.data[7:0];
                    wpush = half_q & ~wfull;
                    wword = {bus.data[7:0], lo_q};
                end else begin
                    wpush = ~wfull;
                    wword = bus.data;
                end
            end else begin
                regs_d[a] = bus.data[7:0];
                if (a == ahp_pkg::TF_CMDSTAT) begin
                    cmd_d = bus.data[7:0];
                    cmd_vld_d = 1'b1;
                    irq_d = 1'b0;
                    if (bus.data[7:0] == ahp_pkg::CMD_SET_FEAT) begin
                        if (regs_q[ahp_pkg::TF_ERROR] ==
                            ahp_pkg::FEAT_8BIT_ON) begin
                            byte_mode_d = 1'b1;
                        end
                        if (regs_q[ahp_pkg::TF_ERROR] ==
                            ahp_pkg::FEAT_8BIT_OFF) begin
                            byte_mode_d = 1'b0;
                        end
                        half_d = 1'b0;
                    end
                end
            end
        end
        if (wr_rise && sel1 && a == ahp_pkg::CB_ALTSTAT) begin
            devctl_d = bus.data[7:0];
        end
        if (rd_fall && sel0) begin
            if (a == ahp_pkg::TF_DATA) begin
                if (byte_mode_q && half_q) begin
                    dd_d = {8'h00, rb_q[0][15:8]};
                    half_d = 1'b0;
                    rpop = 1'b1;
                end else if (byte_mode_q) begin
                    dd_d = {8'h00, rb_q[0][7:0]};
                    half_d = 1'b1;
                end else begin
                    dd_d = rb_q[0];
                    rpop = (rcnt_q != 2'h0);
                end
            end else if (a == ahp_pkg::TF_CMDSTAT) begin
                dd_d = {8'h00, status};
                irq_d = 1'b0;
            end else begin
                dd_d = {8'h00, regs_q[a]};
            end
        end
        if (rd_fall && sel1) begin
            dd_d = {8'h00, status};
        end
        // set wins over a clear in the same cycle
        if (irq_set_i) begin
            irq_d = 1'b1;
        end
    end

    always_comb begin
        wcnt_d = wcnt_q;
        for (int i = 0; i < DEPTH; i++) begin
            wb_d[i] = wb_q[i];
            rb_d[i] = rb_q[i];
        end
        if (wdat_vld_o && wdat_rdy_i) begin
            wb_d[0] = wb_q[1];
            wcnt_d = wcnt_d - 2'h1;
        end
        if (wpush) begin
            wb_d[wcnt_d[0]] = wword;
            wcnt_d = wcnt_d + 2'h1;
        end
        rcnt_d = rcnt_q;
        if (rpop && rcnt_q != 2'h0) begin
            rb_d[0] = rb_q[1];
            rcnt_d = rcnt_d - 2'h1;
        end
        if (rdat_vld_i && rdat_rdy_o) begin
            rb_d[rcnt_d[0]] = rdat_i;
            rcnt_d = rcnt_d + 2'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= 1'b1;
            rd_q <= 1'b1;
            for (int i = 0; i < ahp_pkg::NUM_REGS; i++) begin
                regs_q[i] <= 8'h00;
            end
            for (int i = 0; i < DEPTH; i++) begin
                wb_q[i] <= 16'h0000;
                rb_q[i] <= 16'h0000;
            end
            devctl_q <= 8'h00;
            byte_mode_q <= 1'b0;
            irq_q <= 1'b0;
            cmd_q <= 8'h00;
            cmd_vld_q <= 1'b0;
            lo_q <= 8'h00;
            half_q <= 1'b0;
            wcnt_q <= 2'h0;
            rcnt_q <= 2'h0;
            dd_q <= 16'h0000;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            regs_q <= regs_d;
            wb_q <= wb_d;
            rb_q <= rb_d;
            devctl_q <= devctl_d;
            byte_mode_q <= byte_mode_d;
            irq_q <= irq_d;
            cmd_q <= cmd_d;
            cmd_vld_q <= cmd_vld_d;
            lo_q <= lo_d;
            half_q <= half_d;
            wcnt_q <= wcnt_d;
            rcnt_q <= rcnt_d;
            dd_q <= dd_d;
        end
    end

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    assign bus.dd = dd_q;
    assign bus.dd_oe = ~bus.rd_n & (sel0 | sel1);
    assign bus.intrq = irq_q & ~devctl_q[ahp_pkg::DC_NIEN];
    assign bus.dmareq = 1'b0;
    assign bus.wide_n = 1'b1;
    assign bus.iordy = 1'b1;
    assign cmd_o = cmd_q;
    assign cmd_vld_o = cmd_vld_q;
    assign wdat_o = wb_q[0];
    assign wdat_vld_o = (wcnt_q != 2'h0);

    // ------------------------------------------------------------------
    // role and handshake lines
    // ------------------------------------------------------------------
    logic master_q, master_d;
    logic [ahp_pkg::CNT_W-1:0] pcnt_q, pcnt_d;
    logic seen_q, seen_d, dseen_q, dseen_d;
    always_comb begin
        master_d = master_q;
        if (jumper_i == ahp_pkg::JMP_NONE) begin
            master_d = 1'b1;
        end else if (jumper_i == ahp_pkg::JMP_B_D) begin
            master_d = ~bus.cblsel_n;
        end
        pcnt_d = pcnt_q;
        if (pcnt_q != ahp_pkg::CNT_W'(ahp_pkg::PRESENT_CYC)) begin
            pcnt_d = pcnt_q + 1'b1;
        end
        seen_d = seen_q | (master_q & ~bus.active_in);
        dseen_d = dseen_q | (master_q & ~bus.diag_in);
    end
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            master_q <= 1'b1;
            pcnt_q <= '0;
            seen_q <= 1'b0;
            dseen_q <= 1'b0;
        end else begin
            master_q <= master_d;
            pcnt_q <= pcnt_d;
            seen_q <= seen_d;
            dseen_q <= dseen_d;
        end
    end
    // slave announces itself on both lines for a while after reset
    assign bus.active_out = 1'b0;
    assign bus.active_oe = ~master_q &
        (pcnt_q != ahp_pkg::CNT_W'(ahp_pkg::PRESENT_CYC));
    assign bus.diag_out = 1'b0;
    assign bus.diag_oe = bus.active_oe;
    assign is_master_o = master_q;
    assign slave_seen_o = seen_q;
    assign diag_seen_o = dseen_q;
endmodule

// ---- logic/ahp_host.sv ----
/*
 * host end: runs one pio register or data cycle per request.
 * assumes the drive end sits on the same clock.
 */
`timescale 1ns/1ps
module ahp_host #(
    parameter int STROBE_CYC = 4
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    ahp_if.host              bus,
    input  wire logic        drv_reset_i,
    input  wire logic        req_vld_i,
    output logic             req_rdy_o,
    input  wire logic        req_wr_i,
    input  wire logic        req_ctl_i,
    input  wire logic [2:0]  req_addr_i,
    input  wire logic [15:0] req_data_i,
    output logic [15:0]      rsp_data_o,
    output logic             rsp_vld_o,
    output logic             irq_o
);
    typedef enum logic [1:0] {
        AHP_IDLE   = 2'b00,
        AHP_SETUP  = 2'b01,
        AHP_STROBE = 2'b10,
        AHP_HOLD   = 2'b11
    } ahp_st_t;

    ahp_st_t    st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic       wr_q, wr_d, ctl_q, ctl_d, vld_q, vld_d;
    logic [2:0] a_q, a_d;
    logic [15:0] dat_q, dat_d, rsp_q, rsp_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        wr_d = wr_q;
        ctl_d = ctl_q;
        a_d = a_q;
        dat_d = dat_q;
        rsp_d = rsp_q;
        vld_d = 1'b0;
        case (st_q)
            AHP_IDLE: begin
                if (req_vld_i) begin
                    wr_d = req_wr_i;
                    ctl_d = req_ctl_i;
                    a_d = req_addr_i;
                    dat_d = (req_addr_i == ahp_pkg::TF_DATA && !req_ctl_i) ?
                        req_data_i : {8'h00, req_data_i[7:0]};
                    st_d = AHP_SETUP;
                end
            end
            AHP_SETUP: begin
                cnt_d = 4'(STROBE_CYC);
                st_d = AHP_STROBE;
            end
            AHP_STROBE: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    if (!wr_q) begin
                        rsp_d = bus.data;
                        vld_d = 1'b1;
                    end
                    st_d = AHP_HOLD;
                end
            end
            AHP_HOLD: begin
                st_d = AHP_IDLE;
            end
            default: begin
                st_d = AHP_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= AHP_IDLE;
            cnt_q <= 4'h0;
            wr_q <= 1'b0;
            ctl_q <= 1'b0;
            a_q <= 3'h0;
            dat_q <= 16'h0000;
            rsp_q <= 16'h0000;
            vld_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            wr_q <= wr_d;
            ctl_q <= ctl_d;
            a_q <= a_d;
            dat_q <= dat_d;
            rsp_q <= rsp_d;
            vld_q <= vld_d;
        end
    end

    logic act;
    assign act = (st_q != AHP_IDLE);
    assign req_rdy_o = ~act;
    assign bus.rst_n = ~drv_reset_i;
    assign bus.cs0_n = ~(act & ~ctl_q);
    assign bus.cs1_n = ~(act & ctl_q);
    assign bus.addr = a_q;
    // write strobe rises leaving STROBE, data held one more cycle
    assign bus.wr_n = ~(st_q == AHP_STROBE && wr_q);
    assign bus.rd_n = ~(st_q == AHP_STROBE && !wr_q);
    assign bus.dh = dat_q;
    assign bus.dh_oe = act & wr_q;
    assign bus.dmaack_n = 1'b1;
    assign rsp_data_o = rsp_q;
    assign rsp_vld_o = vld_q;
    assign irq_o = bus.intrq;
endmodule

// ---- bench/ahp_pins_sva.sv ----
/*
 * checker for the pins between the host end and the drive end.
 * assumes one clock and the bench reset on rst_n_i.
 */
`timescale 1ns/1ps
module ahp_pins_sva (
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    input wire logic        rst_n,
    input wire logic        cs0_n,
    input wire logic        cs1_n,
    input wire logic [2:0]  addr,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic        dh_oe,
    input wire logic [15:0] dd,
    input wire logic        dd_oe,
    input wire logic        intrq,
    input wire logic        dmareq,
    input wire logic        wide_n,
    input wire logic        iordy
);
    // ------------------------------------------------------------------
    // pin properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_rd_gate;
        dd_oe == (!rd_n && (cs0_n != cs1_n));
    endproperty
    a_rd_gate: assert property (p_rd_gate)
        else $error("drive bus enable not tied to read strobe");
    property p_no_clash;
        !(dd_oe && dh_oe);
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("both ends drive the data bus");
    // read data settles one cycle into the strobe
    property p_tf_byte;
        dd_oe && $past(dd_oe) && (!cs1_n || addr != ahp_pkg::TF_DATA)
            |-> dd[15:8] == 8'h00;
    endproperty
    a_tf_byte: assert property (p_tf_byte)
        else $error("task-file read uses upper data lines");
    // strobe is four cycles low, the drive takes the write on its rise
    property p_wr_width;
        $fell(wr_n) |-> (!wr_n) [*4] ##1 wr_n;
    endproperty
    a_wr_width: assert property (p_wr_width)
        else $error("write strobe width wrong");
    property p_rd_width;
        $fell(rd_n) |-> (!rd_n) [*4] ##1 rd_n;
    endproperty
    a_rd_width: assert property (p_rd_width)
        else $error("read strobe width wrong");
    property p_sel;
        (!rd_n || !wr_n) |-> cs0_n != cs1_n;
    endproperty
    a_sel: assert property (p_sel)
        else $error("strobe without exactly one select");
    property p_addr;
        (!rd_n || !wr_n) |-> $stable(addr) && $stable(cs0_n) && $stable(cs1_n);
    endproperty
    a_addr: assert property (p_addr)
        else $error("address moved during strobe");
    property p_ready;
        iordy;
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready line pulled");
    property p_dma;
        !dmareq && wide_n;
    endproperty
    a_dma: assert property (p_dma)
        else $error("dma or wide line active");
    property p_bus_rst;
        !rst_n |-> !intrq && !dd_oe;
    endproperty
    a_bus_rst: assert property (p_bus_rst)
        else $error("drive active during bus reset");
endmodule

// ---- bench/ata_host_port_pins_tb.sv ----
/*
 * bench: host end and drive end joined by the pin interface.
 * assumes the bench resolves the data bus and the open-drain lines.
 */
`timescale 1ns/1ps
module ata_host_port_pins_tb;
    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    logic        core_clk_i, rst_n_i, drv_reset_i, req_vld_i, req_wr_i;
    logic        req_ctl_i, rdat_vld_i, wdat_rdy_i, irq_set_i, drq_i;
    logic        cbl_n, pull_n;
    logic [2:0]  req_addr_i;
    logic [15:0] req_data_i, rdat_i;
    logic [3:0]  jumper_i;
    wire         req_rdy_o, rsp_vld_o, irq_o, is_master_o, slave_seen_o;
    wire         diag_seen_o, cmd_vld_o, wdat_vld_o, rdat_rdy_o;
    wire  [15:0] rsp_data_o, wdat_o;
    wire  [7:0]  cmd_o;
    int          bad_count, total_checks, i;
    logic [15:0] wq[$];
    logic [7:0]  last_cmd;

    ahp_if bus ();
    // released bus reads as pulled high, never the last value
    assign bus.data = bus.dd_oe ? bus.dd : bus.dh_oe ? bus.dh : 16'hFFFF;
    assign bus.cblsel_n = cbl_n;
    // pull_n low stands in for a slave holding both lines low
    assign bus.active_in = (bus.active_oe ? bus.active_out : 1'b1) & pull_n;
    assign bus.diag_in = (bus.diag_oe ? bus.diag_out : 1'b1) & pull_n;

    ahp_host ahp_host_inst (.core_clk_i, .rst_n_i, .bus(bus), .drv_reset_i,
        .req_vld_i, .req_rdy_o, .req_wr_i, .req_ctl_i, .req_addr_i,
        .req_data_i, .rsp_data_o, .rsp_vld_o, .irq_o);
    ahp_drive ahp_drive_inst (.core_clk_i, .rst_n_i, .bus(bus), .jumper_i,
        .is_master_o, .slave_seen_o, .diag_seen_o, .cmd_o, .cmd_vld_o,
        .wdat_o, .wdat_vld_o, .wdat_rdy_i, .rdat_i, .rdat_vld_i,
        .rdat_rdy_o, .irq_set_i, .drq_i);
    ahp_pins_sva ahp_pins_sva_inst (.core_clk_i, .rst_n_i,
        .rst_n(bus.rst_n), .cs0_n(bus.cs0_n), .cs1_n(bus.cs1_n),
        .addr(bus.addr), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
        .dh_oe(bus.dh_oe), .dd(bus.dd), .dd_oe(bus.dd_oe),
        .intrq(bus.intrq), .dmareq(bus.dmareq), .wide_n(bus.wide_n),
        .iordy(bus.iordy));

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        if (wdat_vld_o && wdat_rdy_i) wq.push_back(wdat_o);
        if (cmd_vld_o) last_cmd <= cmd_o;
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task op(input logic wr, input logic ctl, input logic [2:0] a,
            input logic [15:0] d, output logic [15:0] q);
        int n;
        logic got;
        @(negedge core_clk_i);
        req_vld_i = 1'b1;
        req_wr_i = wr;
        req_ctl_i = ctl;
        req_addr_i = a;
        req_data_i = d;
        while (req_rdy_o !== 1'b1) @(negedge core_clk_i);
        @(negedge core_clk_i);
        req_vld_i = 1'b0;
        got = wr;
        q = 16'h0000;
        for (n = 0; n < 30 && !(got && req_rdy_o === 1'b1); n++) begin
            @(negedge core_clk_i);
            if (rsp_vld_o === 1'b1) begin
                q = rsp_data_o;
                got = 1'b1;
            end
        end
        if (n == 30) bad_count++;
    endtask

    task wr(input logic [2:0] a, input logic [15:0] d);
        logic [15:0] q;
        op(1'b1, 1'b0, a, d, q);
    endtask

    task rd(input logic ctl, input logic [2:0] a, input logic [15:0] exp);
        logic [15:0] q;
        op(1'b0, ctl, a, 16'h0000, q);
        chk(q, exp);
    endtask

    task role(input logic [3:0] j, input logic c, input logic exp);
        @(negedge core_clk_i);
        jumper_i = j;
        cbl_n = c;
        repeat (4) @(negedge core_clk_i);
        chk(16'(is_master_o), 16'(exp));
    endtask

    task feed(input logic [15:0] w);
        @(negedge core_clk_i);
        rdat_vld_i = 1'b1;
        rdat_i = w;
        while (rdat_rdy_o !== 1'b1) @(negedge core_clk_i);
        @(negedge core_clk_i);
        rdat_vld_i = 1'b0;
    endtask

    task end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        #100us;
        bad_count++;
        end_of_test();
    end

    initial begin
        {rst_n_i, drv_reset_i, req_vld_i, req_wr_i, req_ctl_i} = 5'h00;
        {rdat_vld_i, irq_set_i, drq_i, pull_n} = 4'h0;
        {wdat_rdy_i, cbl_n} = 2'h3;
        req_addr_i = 3'h0;
        req_data_i = 16'h0000;
        rdat_i = 16'h0000;
        jumper_i = ahp_pkg::JMP_NONE;
        repeat (8) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        chk(16'(is_master_o), 16'h0001);
        chk(16'(bus.intrq), 16'h0000);
        repeat (300) @(negedge core_clk_i);
        chk(16'(slave_seen_o), 16'h0001);
        chk(16'(diag_seen_o), 16'h0001);
        pull_n = 1'b1;
        // upper byte is junk: only the low lines may carry it
        for (i = 2; i < 6; i++) wr(i[2:0], {8'hC3, 8'h10 + 8'(i)});
        for (i = 2; i < 6; i++) rd(1'b0, i[2:0], {8'h00, 8'h10 + 8'(i)});
        // third word meets a full buffer and is dropped
        wdat_rdy_i = 1'b0;
        wr(ahp_pkg::TF_DATA, 16'h1234);
        wr(ahp_pkg::TF_DATA, 16'h5678);
        wr(ahp_pkg::TF_DATA, 16'h9ABC);
        wdat_rdy_i = 1'b1;
        repeat (6) @(negedge core_clk_i);
        chk(16'(wq.size()), 16'h0002);
        chk(wq[0], 16'h1234);
        chk(wq[1], 16'h5678);
        wq.delete();
        feed(16'hBEEF);
        rd(1'b0, ahp_pkg::TF_DATA, 16'hBEEF);
        wr(ahp_pkg::TF_ERROR, 16'(ahp_pkg::FEAT_8BIT_ON));
        wr(ahp_pkg::TF_CMDSTAT, 16'(ahp_pkg::CMD_SET_FEAT));
        @(negedge core_clk_i);
        chk(16'(last_cmd), 16'(ahp_pkg::CMD_SET_FEAT));
        wr(ahp_pkg::TF_DATA, 16'hFF34);
        wr(ahp_pkg::TF_DATA, 16'hFF12);
        // byte mode: low byte first, high byte pops the word
        feed(16'hA55A);
        rd(1'b0, ahp_pkg::TF_DATA, 16'h005A);
        rd(1'b0, ahp_pkg::TF_DATA, 16'h00A5);
        wr(ahp_pkg::TF_ERROR, 16'(ahp_pkg::FEAT_8BIT_OFF));
        wr(ahp_pkg::TF_CMDSTAT, 16'(ahp_pkg::CMD_SET_FEAT));
        wr(ahp_pkg::TF_DATA, 16'hCAFE);
        repeat (4) @(negedge core_clk_i);
        chk(wq[0], 16'h1234);
        chk(wq[1], 16'hCAFE);
        drq_i = 1'b1;
        irq_set_i = 1'b1;
        @(negedge core_clk_i);
        irq_set_i = 1'b0;
        @(negedge core_clk_i);
        chk(16'(irq_o), 16'h0001);
        rd(1'b1, ahp_pkg::CB_ALTSTAT, 16'h0048);
        chk(16'(irq_o), 16'h0001);
        rd(1'b0, ahp_pkg::TF_CMDSTAT, 16'h0048);
        repeat (2) @(negedge core_clk_i);
        chk(16'(irq_o), 16'h0000);
        role(ahp_pkg::JMP_B_D, 1'b1, 1'b0);
        role(ahp_pkg::JMP_B_D, 1'b0, 1'b1);
        role(ahp_pkg::JMP_NONE, 1'b1, 1'b1);
        irq_set_i = 1'b1;
        @(negedge core_clk_i);
        irq_set_i = 1'b0;
        drv_reset_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        chk(16'(irq_o), 16'h0000);
        drv_reset_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        // a slave announces itself on both lines after a bus reset
        role(ahp_pkg::JMP_B_D, 1'b1, 1'b0);
        drv_reset_i = 1'b1;
        @(negedge core_clk_i);
        drv_reset_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        chk(16'(bus.active_in), 16'h0000);
        chk(16'(bus.diag_in), 16'h0000);
        repeat (200) @(negedge core_clk_i);
        chk(16'(bus.active_in), 16'h0001);
        chk(16'(bus.diag_in), 16'h0001);
        end_of_test();
    end
endmodule
